// [hw/acs_params.svh]
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Control word field positions
`define ACS_CTRL_W          12
`define ACS_SEQ_BIT         1
`define ACS_SHADOW_BIT      2
`define ACS_CFG_LO          3
`define ACS_CFG_HI          4
`define ACS_ADDR_LO         5
`define ACS_ADDR_HI         7
`define ACS_CTRL_RESET      12'h000
`define ACS_SHADOW_RESET    8'h00

// Conversion length in conversion-clock periods
`define ACS_CONV_PERIODS    4'hD

`endif

// [hw/acs_pkg.sv]
package acs_pkg;

    // Input configuration codes (bit1, bit0)
    typedef enum logic [1:0] {
        ACS_CFG_SINGLE = 2'h0,
        ACS_CFG_PSEUDO1 = 2'h1,
        ACS_CFG_DIFF   = 2'h2,
        ACS_CFG_PSEUDO2 = 2'h3
    } acs_cfg_t;

    // Negative-side selector: ground or an input number
    typedef struct packed {
        logic       neg_is_ground;
        logic [2:0] neg_input;
        logic [2:0] pos_input;
    } acs_pair_t;

endpackage : acs_pkg

// [hw/acs_pair_decode.sv]
// Maps channel number and input configuration to an input pair
module acs_pair_decode (
    input  wire logic [2:0]       chan,
    input  wire logic [1:0]       cfg,
    output acs_pkg::acs_pair_t    pair
);
    wire logic is_single = (cfg == acs_pkg::ACS_CFG_SINGLE);
    wire logic is_ps2    = (cfg == acs_pkg::ACS_CFG_PSEUDO2);

    // Pairs swap polarity on odd addresses; second pseudo uses input 7
    assign pair.pos_input     = chan;                                // [RL3]
    assign pair.neg_is_ground = is_single;                           // [RL3]
    assign pair.neg_input     = is_single ? 3'h0 :
                                is_ps2    ? 3'h7 :                   // [RL6]
                                {chan[2:1], ~chan[0]};          // [RL4] [RL5]
endmodule : acs_pair_decode

// [hw/acs_conv_timer.sv]
`include "acs_params.svh"

// Counts conversion-clock periods after a start; a new start aborts
module acs_conv_timer (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic clk_rise,
    output logic      busy,
    output logic      done
);
    logic [3:0] periods;
    wire  logic last = (periods == (`ACS_CONV_PERIODS - 4'h1));

    // Done only after all periods; a restart drops the unfinished one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            periods <= 4'h0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy    <= 1'b1;                                     // [RL1]
                periods <= 4'h0;
            end else if (busy && clk_rise) begin
                periods <= periods + 4'h1;
                if (last) begin
                    busy <= 1'b0;
                    done <= 1'b1;                                    // [RL1]
                end
            end
        end
    end
endmodule : acs_conv_timer

// [hw/acs_sequencer.sv]
`include "acs_params.svh"

// Channel sequencer for an eight-input converter. The host writes a
// twelve-bit control word, and optionally a channel-enable byte, over a
// parallel strobe bus. Each convert strobe then picks the next input pair
// and starts a conversion timer that counts periods of the conversion clock pin.
// Every pin passes two flip-flops first, so edges show up about three
// ref_clk cycles late; host timing is far slower, so nothing is lost.
// Limitation: the analog switches themselves live outside this block;
// only the selected pair numbers leave it.

// Behaviour
// RL1: a conversion completes only after 13 full conversion clock periods.
// RL2: host gives strobe rise or clock fall before reprogramming after abort.
// RL3: single-ended: addressed input positive, analog ground negative.
// RL4: fully differential pairs 0/1..6/7; odd address swaps polarity.
// RL5: first pseudo mode uses the same pairing as fully differential.
// RL6: second pseudo: inputs 0..6 against input 7; address 7 not allowed.
// RL7: sequence 0 shadow 0: each conversion uses last written address.
// RL8: sequence 0 shadow 1: next write loads low eight bits to shadow.
// RL9: sequence 1 shadow 0: write updates fields, sequence keeps running.
// RL10: both bits 1: consecutive channels from 0 up to address.
// RL11: shadow is 8-bit write-only, loaded on write strobe rising edge.
// RL12: shadow load only when previous control write selected shadow.
// RL13: shadow bit n enables input channel n.
// RL14: host sets one bit per input, or both bits per pair.
// RL15: each strobe steps ascending through enabled channels, wrapping.
// RL16: sequencing persists until a write other than sequence 1 shadow 0.
// RL17: paired modes convert each enabled pair once, normal polarity.
// RL18: 12-bit write-only control word; field positions as defined.
// RL19: control resets to zero: sequencer off, channel 0 single-ended.
// RL20: a newly programmed sequence restarts at lowest enabled channel.
module acs_sequencer (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        chip_select_n,
    input  wire logic        write_strobe_n,
    input  wire logic [11:0] data_line,
    input  wire logic        convert_strobe_n,
    input  wire logic        conversion_clock_in,
    output logic [11:0]      control_word,
    output logic [2:0]       pos_input,
    output logic [2:0]       neg_input,
    output logic             neg_is_ground,
    output logic             seq_active,
    output logic             conv_busy,
    output logic             conv_done
);
    // Two-flop synchronisers for all pins
    logic [1:0]  cs_sy;                    // Chip select, active low
    logic [1:0]  wr_sy;                    // Write strobe, active low
    logic [1:0]  cv_sy;                    // Convert strobe, active low
    logic [1:0]  ck_sy;                    // Conversion clock
    logic [11:0] data_s1;                  // Data bus, first stage
    logic [11:0] data_s2;                  // Data bus, second stage
    // Delayed copies for edge detection
    logic        wr_d;
    logic        cv_d;
    logic        ck_d;
    // Sequencer state
    logic [7:0]  sequence_channel_enables;
    logic        shadow_armed;             // Next write goes to the shadow
    logic        restart;                  // Next step takes lowest channel
    logic [2:0]  cur_chan;
    logic [2:0]  pos_q;

    // Control pins idle high and the clock idles low, even in reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_sy <= 2'h3;
            wr_sy <= 2'h3;
            cv_sy <= 2'h3;
            ck_sy <= 2'h0;
        end else begin
            cs_sy <= {cs_sy[0], chip_select_n};
            wr_sy <= {wr_sy[0], write_strobe_n};
            cv_sy <= {cv_sy[0], convert_strobe_n};
            ck_sy <= {ck_sy[0], conversion_clock_in};
        end
    end

    // Data bus takes the same two stages, so it lines up with the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_s1 <= 12'h000;
            data_s2 <= 12'h000;
        end else begin
            data_s1 <= data_line;
            data_s2 <= data_s1;
        end
    end

    // Edge detectors read only the second synchroniser stage; reset
    // values match the idle pin levels so no false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_d <= 1'b1;
        end else begin
            wr_d <= wr_sy[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cv_d <= 1'b1;
        end else begin
            cv_d <= cv_sy[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ck_d <= 1'b0;
        end else begin
            ck_d <= ck_sy[1];
        end
    end

    // Write commits on strobe rise while selected; data is stable then
    wire logic wr_rise  = wr_sy[1] & ~wr_d & ~cs_sy[1];             // [RL11]
    wire logic cv_fall  = ~cv_sy[1] & cv_d;
    wire logic ck_rise  = ck_sy[1] & ~ck_d;

    // Fields of the incoming word and of the stored control word
    wire logic       new_seq  = data_s2[`ACS_SEQ_BIT];
    wire logic       new_shadow_select_bit = data_s2[`ACS_SHADOW_BIT];
    wire logic [2:0] addr     = control_word[`ACS_ADDR_HI:`ACS_ADDR_LO];
    wire logic [1:0] cfg      = control_word[`ACS_CFG_HI:`ACS_CFG_LO];
    wire logic       paired   = (cfg == acs_pkg::ACS_CFG_DIFF) ||
                                (cfg == acs_pkg::ACS_CFG_PSEUDO1);

    // Shadow load replaces a control write when armed
    wire logic shadow_load = wr_rise & shadow_armed;                 // [RL12]
    wire logic ctrl_write  = wr_rise & ~shadow_armed;                // [RL18]
    wire logic keep_seq    = new_seq & ~new_shadow_select_bit;                    // [RL9]
    wire logic consec      = new_seq & new_shadow_select_bit;                     // [RL10]

    // Consecutive mode: enable mask is channels 0..final address
    function automatic logic [7:0] upto_mask(input logic [2:0] last);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (3'(i) <= last);
        end
        return m;
    endfunction : upto_mask

    // Next enabled channel strictly above 'from' (lowest enabled when 'first'), wrapping to lowest
    function automatic logic [2:0] next_enabled(input logic [7:0] en,
                                                input logic [2:0] from,
                                                input logic       first,
                                                input logic       pr);
        logic [2:0] r;
        logic       hit;
        logic [7:0] e;
        r   = from;
        hit = 1'b0;
        e   = en;
        // Paired modes: an odd bit never names a channel of its own
        if (pr) begin
            for (int k = 1; k < 8; k += 2) begin
                e[k] = 1'b0;                                         // [RL17]
            end
        end
        // First pass: lowest enabled channel above the current one, or lowest of all when first
        for (int i = 0; i < 8; i++) begin
            if (!hit && e[i] && (first || 3'(i) > from)) begin
                r   = 3'(i);
                hit = 1'b1;
            end
        end
        // Second pass wraps round to the lowest enabled channel
        for (int i = 0; i < 8; i++) begin
            if (!hit && e[i]) begin
                r   = 3'(i);                                         // [RL15]
                hit = 1'b1;
            end
        end
        return r;
    endfunction : next_enabled

    wire logic [2:0] next_chan = next_enabled(sequence_channel_enables,
                                              cur_chan, restart, paired);

    // Next values; a shadow load outranks a control write
    wire logic [2:0]  new_addr  = data_s2[`ACS_ADDR_HI:`ACS_ADDR_LO];
    wire logic [7:0]  ramp_mask = upto_mask(new_addr);               // [RL10]
    wire logic [11:0] next_control_word =
        ctrl_write ? data_s2 : control_word;                         // [RL18]
    wire logic [7:0]  next_sequence_channel_enables =
        shadow_load            ? data_s2[7:0] :              // [RL8] [RL13]
        (ctrl_write && consec) ? ramp_mask    :                      // [RL10]
                                 sequence_channel_enables;
    // Arm flag: only the write right after a shadow-select write loads
    wire logic next_shadow_armed =
        shadow_load ? 1'b0 :
        ctrl_write  ? (~new_seq & new_shadow_select_bit) :                        // [RL8]
                      shadow_armed;
    // A write with sequence 1, shadow 0 leaves the running sequence alone
    wire logic next_seq_active =
        (shadow_load || (ctrl_write && consec)) ? 1'b1 :
        (ctrl_write && !keep_seq)               ? 1'b0 :    // [RL16] [RL7]
                                                  seq_active;
    // Pointer restarts on a new program and clears on the first step
    wire logic next_restart =
        (shadow_load || (ctrl_write && consec)) ? 1'b1    :          // [RL20]
        ctrl_write                              ? restart :
        (cv_fall && seq_active)                 ? 1'b0    :
                                                  restart;

    // Control word resets to zero: sequencer off, channel 0 single-ended
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            control_word <= `ACS_CTRL_RESET;                         // [RL19]
        end else begin
            control_word <= next_control_word;
        end
    end

    // Channel enables are write-only; the host can never read them back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sequence_channel_enables <= `ACS_SHADOW_RESET;
        end else begin
            sequence_channel_enables <= next_sequence_channel_enables;
        end
    end

    // Arm flag for the shadow load
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shadow_armed <= 1'b0;
        end else begin
            shadow_armed <= next_shadow_armed;
        end
    end

    // Sequencer running flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seq_active <= 1'b0;
        end else begin
            seq_active <= next_seq_active;
        end
    end

    // Restart is set at reset so the first step takes the lowest channel
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            restart <= 1'b1;
        end else begin
            restart <= next_restart;
        end
    end

    // Sequencer picks the next enabled channel; otherwise the address
    wire logic [2:0] next_cur_chan = seq_active ? next_chan : addr;

    // Channel for each conversion is latched on the strobe falling edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_chan <= 3'h0;
        end else if (cv_fall) begin
            cur_chan <= next_cur_chan;                       // [RL7] [RL15]
        end
    end

    acs_pkg::acs_pair_t pair;
    acs_pair_decode u_decode (
        .chan (cur_chan),
        .cfg  (cfg),
        .pair (pair)
    );

    // Registered pair outputs; host keeps address 7 out of pseudo mode 2
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pos_q <= 3'h0;
        end else begin
            pos_q <= pair.pos_input;                                 // [RL3]
        end
    end

    // Negative side is a pair partner, input 7, or unused under ground
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            neg_input <= 3'h0;
        end else begin
            neg_input <= pair.neg_input;                             // [RL6]
        end
    end

    // Ground flag resets high: channel 0 single-ended after reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            neg_is_ground <= 1'b1;                                   // [RL19]
        end else begin
            neg_is_ground <= pair.neg_is_ground;
        end
    end
    assign pos_input = pos_q;

    // Strobe fall starts a conversion; a fresh strobe aborts a short clock burst,
    // since it simply restarts the period count without a done
    acs_conv_timer u_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (cv_fall),
        .clk_rise (ck_rise),
        .busy     (conv_busy),
        .done     (conv_done)
    );
endmodule : acs_sequencer

// [tb/acs_seq_properties.sv]
module acs_seq_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        chip_select_n,
    input wire logic [11:0] control_word,
    input wire logic [2:0]  pos_input,
    input wire logic [2:0]  neg_input,
    input wire logic        neg_is_ground,
    input wire logic        seq_active,
    input wire logic        conv_busy,
    input wire logic        conv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Input configuration field; a write mid-start would blur the checks
    wire logic [1:0] cfg = control_word[4:3];
    a_reset_state: assert property ($rose(rst_n) |->
        control_word == 12'h000 && neg_is_ground && !seq_active)
        else $error("Bad state after reset");
    a_done_pulse: assert property (conv_done |=> !conv_done)
        else $error("Done longer than one cycle");
    a_done_cause: assert property (conv_done |-> $past(conv_busy))
        else $error("Done without conversion");
    a_busy_min: assert property ($rose(conv_busy) |-> conv_busy[*8])
        else $error("Conversion ended too early");
    a_single_sel: assert property ($rose(conv_busy) && !seq_active &&
        cfg == 2'h0 |=> neg_is_ground && pos_input == $past(control_word[7:5]))
        else $error("Wrong single-ended input");
    a_pair_sel: assert property ($rose(conv_busy) && !seq_active &&
        cfg inside {2'h1, 2'h2} |=> !neg_is_ground &&
        pos_input == $past(control_word[7:5]) && neg_input == (pos_input ^ 3'h1))
        else $error("Wrong differential pair");
    a_common_neg: assert property ($rose(conv_busy) && cfg == 2'h3 |=>
        !neg_is_ground && neg_input == 3'h7 && pos_input != 3'h7)
        else $error("Wrong common negative input");
    a_seq_even: assert property ($rose(conv_busy) && seq_active &&
        cfg inside {2'h1, 2'h2} |=> !pos_input[0] && neg_input == pos_input + 3'h1)
        else $error("Inverse pair in sequence");
    a_ctrl_write: assert property ($changed(control_word) |->
        !$past(chip_select_n)) else $error("Control changed without write");
    a_seq_stop: assert property ($fell(seq_active) |->
        !$past(chip_select_n)) else $error("Sequence stopped without write");
endmodule : acs_seq_checker

bind acs_sequencer acs_seq_checker u_chk (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .chip_select_n (chip_select_n),
    .control_word  (control_word),
    .pos_input     (pos_input),
    .neg_input     (neg_input),
    .neg_is_ground (neg_is_ground),
    .seq_active    (seq_active),
    .conv_busy     (conv_busy),
    .conv_done     (conv_done)
);

// [tb/acs_host_model.sv]
module acs_host_model (
    input  wire logic   ref_clk,
    output logic        chip_select_n,
    output logic        write_strobe_n,
    output logic [11:0] data_line,
    output logic        convert_strobe_n,
    output logic        conversion_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus; the conversion clock stands still outside conversions
    initial begin
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        data_line = 12'h000;
        convert_strobe_n = 1'b1;
        conversion_clock_in = 1'b0;
    end
    // Write cycle; released data is inverted so stale values never match
    task automatic wr(logic [11:0] d);
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        data_line = d;
        write_strobe_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        write_strobe_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        chip_select_n = 1'b1;
        data_line = ~d;
    endtask : wr
    // Strobe pulse then n conversion clock periods of six cycles
    task automatic conv(int n);
        @(negedge ref_clk);
        convert_strobe_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        convert_strobe_n = 1'b1;
        repeat (n) begin
            conversion_clock_in = 1'b1;
            repeat (3) @(negedge ref_clk);
            conversion_clock_in = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
        repeat (6) @(negedge ref_clk);
    endtask : conv
endmodule : acs_host_model

// [tb/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk;
    logic rst_n;
    logic chip_select_n, write_strobe_n, convert_strobe_n, conversion_clock_in;
    logic [11:0] data_line, control_word;
    logic [2:0] pos_input, neg_input;
    logic neg_is_ground, seq_active, conv_busy, conv_done;
    logic [6:0] expq[$];
    logic [6:0] seen;
    logic [1:0] cf;
    int fails = 0, total_checks = 0, seed, ptr, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    assign seen = {neg_is_ground, neg_is_ground ? 3'h0 : neg_input, pos_input};
    acs_host_model host (.ref_clk(ref_clk), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .data_line(data_line),
        .convert_strobe_n(convert_strobe_n),
        .conversion_clock_in(conversion_clock_in));
    acs_sequencer dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .data_line(data_line), .convert_strobe_n(convert_strobe_n),
        .conversion_clock_in(conversion_clock_in),
        .control_word(control_word), .pos_input(pos_input),
        .neg_input(neg_input), .neg_is_ground(neg_is_ground),
        .seq_active(seq_active), .conv_busy(conv_busy), .conv_done(conv_done));
    task automatic check(logic [11:0] s, logic [11:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Expected pair {ground, negative, positive}; ground shows negative 0
    function automatic logic [6:0] pr(int c, logic [1:0] f);
        case (f)
            2'h0: pr = {4'h8, 3'(c)};
            2'h3: pr = {4'h7, 3'(c)};
            default: pr = {1'b0, 3'(c ^ 1), 3'(c)};
        endcase
    endfunction : pr
    function automatic int nxt(int p, logic [7:0] m);
        for (int i = 1; i <= 8; i++)
            if (m[(p + i) % 8])
                return (p + i) % 8;
        return p;
    endfunction : nxt
    task automatic cv(int c);
        expq.push_back(pr(c, cf));
        host.conv(13);
    endtask : cv
    task automatic sq(int k, logic [7:0] m);
        repeat (k) begin
            ptr = nxt(ptr, m);
            cv(ptr);
        end
    endtask : sq
    // Each finished conversion retires the oldest expected pair
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
        if (conv_done === 1'b1) begin
            if (expq.size() == 0)
                check(12'h001, 12'h000);
            else
                check(12'(seen), 12'(expq.pop_front()));
        end
    end
    initial begin
        logic [11:0] w;
        logic [7:0] m;
        int a;
        ref_clk = 1'b0;
        rst_n = 1'b0;
        seed = 32'h0c66a83a;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        @(negedge ref_clk);
        check(control_word, 12'h000);
        check({11'h0, neg_is_ground}, 12'h001);
        for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 8; c++) begin
                if (f == 3 && c == 7)
                    continue;
                w = 12'($random(seed)) & 12'hF01 | 12'(c << 5) | 12'(f << 3);
                host.wr(w);
                check(control_word, w);
                cf = 2'(f);
                cv(c);
            end
        end
        $display("test direct selection done");
        expq.push_back(pr(6, cf));
        host.conv(5);
        host.conv(13);
        $display("test abort done");
        host.wr(12'h004);
        m = 8'($random(seed)) | 8'h01;
        host.wr({4'hA, m});
        check(control_word, 12'h004);
        cf = 2'h0;
        ptr = 7;
        sq(4, m);
        host.wr(12'h902);
        check({11'h0, seq_active}, 12'h001);
        sq(6, m);
        host.wr(12'h060);
        check({11'h0, seq_active}, 12'h000);
        cv(3);
        $display("test shadow sequence done");
        m = 8'($random(seed)) & 8'h55 | 8'h01;
        host.wr(12'h014);
        host.wr({4'h0, m | m << 1});
        cf = 2'h2;
        ptr = 7;
        sq(6, m);
        $display("test paired sequence done");
        a = {$random(seed)} % 8;
        cf = 2'h0;
        host.wr(12'(a << 5) | 12'h006);
        ptr = 7;
        sq(10, 8'hFF >> (7 - a));
        $display("test consecutive done");
        check(12'(expq.size()), 12'h000);
        final_report();
    end
endmodule : testbench
